// >>> tb/core_event_model.sv
`timescale 1ns/100ps
// Stands in for the core pipeline: event lines and the instruction-boundary strobe.
module core_event_model (
  input wire logic i_clock,
  output logic o_boundary,
  output logic [17:0] o_events
);
  // Idle keeps virtual NMI blocking up, so no window exit fires on its own.
  initial begin
    o_boundary = 1'b0;
    o_events = 18'h02000;
  end
  // Presents one event set for exactly one boundary cycle.
  task automatic fire(input logic [17:0] ev);
    @(posedge i_clock);
    o_boundary <= 1'b1;
    o_events <= ev;
    @(posedge i_clock);
    o_boundary <= 1'b0;
    o_events <= 18'h02000;
  endtask
endmodule

// >>> tb/guest_exit_cause_encoder_chk.sv
`timescale 1ns/100ps
// Watches the capture port of the cause encoder.
module guest_exit_cause_encoder_chk (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_boundary,
  input wire logic i_processor_identify_instruction,
  input wire logic i_secure_env_leaf_instruction,
  input wire logic i_entry_fail,
  input wire logic [15:0] i_entry_fail_reason,
  input wire logic o_store_valid,
  input wire logic [31:0] o_store_cause,
  input wire logic o_guest_exit
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  property p_upper; o_store_valid |-> o_store_cause[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_exv; o_guest_exit |-> o_store_valid; endproperty
  a_exv: assert property (p_exv) else $error("exit without store");
  property p_uncond;
    i_boundary && (i_processor_identify_instruction || i_secure_env_leaf_instruction)
      |=> o_store_valid && o_guest_exit;
  endproperty
  a_uncond: assert property (p_uncond) else $error("no exit");
  property p_entry;
    i_entry_fail && !i_boundary |=> o_store_valid && !o_guest_exit &&
      o_store_cause[15:0] == $past(i_entry_fail_reason);
  endproperty
  a_entry: assert property (p_entry) else $error("entry word wrong");
  property p_idle; !i_boundary && !i_entry_fail |=> !o_store_valid; endproperty
  a_idle: assert property (p_idle) else $error("stray store");
  property p_hold; !o_store_valid |-> $stable(o_store_cause); endproperty
  a_hold: assert property (p_hold) else $error("cause moved");
  property p_bnd; o_guest_exit |-> $past(i_boundary); endproperty
  a_bnd: assert property (p_bnd) else $error("exit off boundary");
  property p_range; o_guest_exit |-> o_store_cause[15:0] <= 16'h000c; endproperty
  a_range: assert property (p_range) else $error("code out of range");
  c_exit: cover property (o_guest_exit);
  c_entry: cover property (o_store_valid && !o_guest_exit);
  c_back: cover property (o_store_valid [*2]);
endmodule
bind guest_exit_cause_encoder guest_exit_cause_encoder_chk chk_i (.i_clock(i_clock),
  .i_nrst(i_nrst), .i_boundary(i_boundary),
  .i_processor_identify_instruction(i_processor_identify_instruction),
  .i_secure_env_leaf_instruction(i_secure_env_leaf_instruction), .i_entry_fail(i_entry_fail),
  .i_entry_fail_reason(i_entry_fail_reason), .o_store_valid(o_store_valid),
  .o_store_cause(o_store_cause), .o_guest_exit(o_guest_exit));

// >>> tb/guest_exit_cause_encoder_test.sv
`timescale 1ns/100ps
// Drives the encoder over APB and through the core model.
module guest_exit_cause_encoder_test;
  logic i_clock, i_nrst, psel, penable, pwrite, efail, pready, pslverr, sv, ge, irq, bnd, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, sc;
  logic [15:0] efr;
  logic [17:0] ev;
  int bad_count = 0;
  int n_checks = 0;
  core_event_model core (.i_clock(i_clock), .o_boundary(bnd), .o_events(ev));
  guest_exit_cause_encoder dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_boundary(bnd),
    .i_exception(ev[0]), .i_exception_bitmap_hit(ev[1]), .i_double_fault_invoke(ev[2]),
    .i_nmi(ev[3]), .i_external_interrupt(ev[4]), .i_init_signal(ev[5]),
    .i_startup_interprocessor_interrupt(ev[6]), .i_wait_for_startup_state(ev[7]),
    .i_system_management_interrupt(ev[8]), .i_after_io_retire(ev[9]),
    .i_interrupt_enable_flag(ev[10]), .i_set_interrupt_blocking(ev[11]),
    .i_stack_segment_load_blocking(ev[12]), .i_virtual_nmi_blocking(ev[13]),
    .i_task_switch(ev[14]), .i_processor_identify_instruction(ev[15]),
    .i_secure_env_leaf_instruction(ev[16]), .i_halt_instruction(ev[17]),
    .i_entry_fail(efail), .i_entry_fail_reason(efr), .o_store_valid(sv),
    .o_store_cause(sc), .o_guest_exit(ge), .o_irq(irq));
  // The 20 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Every code from a table; the last three rows run with all exiting controls off.
  task automatic t_codes();
    logic [17:0] evs [19] = '{18'h02003, 18'h02008, 18'h02010, 18'h02005, 18'h02020,
      18'h020c0, 18'h02300, 18'h02100, 18'h02400, 18'h00000, 18'h06000, 18'h0a000,
      18'h12000, 18'h22000, 18'h2a000, 18'h06020, 18'h22000, 18'h02010, 18'h2a000};
    logic [15:0] codes [19] = '{16'h0, 16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6,
      16'h7, 16'h8, 16'h9, 16'ha, 16'hb, 16'hc, 16'ha, 16'h3, 16'hffff, 16'hffff, 16'ha};
    logic v;
    apb(1'b0, exit_cause_pkg::CAUSE_OFFSET, 32'h0);
    chk("cause reset", 32'h0, rd);
    for (int i = 0; i < 19; i++) begin
      apb(1'b1, exit_cause_pkg::CONTROL_OFFSET, (i < 16) ? 32'h1f : 32'h0);
      core.fire(evs[i]);
      #1;
      v = (codes[i] != 16'hffff);
      chk("store exit", {30'h0, v, v}, {30'h0, sv, ge});
      if (v) chk("cause", {16'h0, codes[i]}, sc);
    end
    $display("test codes done");
  endtask
  // Status, mask, interrupt, read-only cause, entry failure and an unmapped read.
  task automatic t_irq();
    apb(1'b1, exit_cause_pkg::STATUS_OFFSET, 32'h3);
    apb(1'b1, exit_cause_pkg::MASK_OFFSET, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    core.fire(18'h0a000);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, exit_cause_pkg::STATUS_OFFSET, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b1, exit_cause_pkg::CAUSE_OFFSET, 32'hffff);
    apb(1'b0, exit_cause_pkg::CAUSE_OFFSET, 32'h0);
    chk("cause reg", 32'ha, rd);
    apb(1'b1, exit_cause_pkg::STATUS_OFFSET, 32'h1);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge i_clock);
    efail <= 1'b1;
    efr <= 16'h0021;
    @(posedge i_clock);
    efail <= 1'b0;
    #1;
    chk("entry cause", 32'h0000_0021, sc);
    chk("entry store", 32'h2, {30'h0, sv, ge});
    apb(1'b0, exit_cause_pkg::STATUS_OFFSET, 32'h0);
    chk("status", 32'h2, rd);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    $display("test irq done");
  endtask
  // Reset in mid-run: control and cause registers, capture port and interrupt return to their reset values.
  task automatic t_reset();
    apb(1'b1, exit_cause_pkg::CONTROL_OFFSET, 32'h1f);
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    #1;
    chk("reset outs", 32'h0, {29'h0, sv, ge, irq});
    apb(1'b0, exit_cause_pkg::CONTROL_OFFSET, 32'h0);
    chk("control reset", 32'h0, rd);
    apb(1'b0, exit_cause_pkg::CAUSE_OFFSET, 32'h0);
    chk("cause reset", 32'h0, rd);
    $display("test reset done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    {i_nrst, psel, penable, pwrite, efail, paddr, pwdata, efr} = '0;
    repeat (4) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_codes();
    t_irq();
    t_reset();
    conclude();
  end
  // Watchdog at 2000 cycles, well beyond the under 200 cycles the tests need.
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule

// >>> verilog/exit_cause_pkg.sv
package exit_cause_pkg;
  // Register byte offsets on the APB bus; ENTRY_FAIL_OFFSET is not decoded and answers with an error.
  localparam logic [7:0] CAUSE_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0c;
  localparam logic [7:0] ENTRY_FAIL_OFFSET = 8'h10;
  // Control register field positions.
  localparam int CTL_NMI_EXIT_BIT = 0;
  localparam int CTL_EXT_EXIT_BIT = 1;
  localparam int CTL_INTWIN_EXIT_BIT = 2;
  localparam int CTL_NMIWIN_EXIT_BIT = 3;
  localparam int CTL_HALT_EXIT_BIT = 4;
  localparam int CTL_WIDTH = 5;
  // Status register field positions.
  localparam int STS_EXIT_BIT = 0;
  localparam int STS_ENTRY_FAIL_BIT = 1;
  localparam int STS_WIDTH = 2;
  // Reset values.
  localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 5'h00;
  localparam logic [STS_WIDTH-1:0] MASK_RESET = 2'h0;
  // Basic reason codes.
  localparam logic [15:0] RSN_EXCEPTION_NMI = 16'h0000;
  localparam logic [15:0] RSN_EXT_INT = 16'h0001;
  localparam logic [15:0] RSN_TRIPLE_FAULT = 16'h0002;
  localparam logic [15:0] RSN_INIT = 16'h0003;
  localparam logic [15:0] RSN_STARTUP = 16'h0004;
  localparam logic [15:0] RSN_IO_SMI = 16'h0005;
  localparam logic [15:0] RSN_OTHER_SMI = 16'h0006;
  localparam logic [15:0] RSN_INT_WINDOW = 16'h0007;
  localparam logic [15:0] RSN_NMI_WINDOW = 16'h0008;
  localparam logic [15:0] RSN_TASK_SWITCH = 16'h0009;
  localparam logic [15:0] RSN_IDENTIFY = 16'h000a;
  localparam logic [15:0] RSN_SECURE_LEAF = 16'h000b;
  localparam logic [15:0] RSN_HALT = 16'h000c;
endpackage

// >>> verilog/guest_exit_cause_encoder.sv
`timescale 1ns/100ps
// Encodes the cause of a guest exit and writes it to the control structure store.
module guest_exit_cause_encoder (
  input wire logic i_clock,
  input wire logic i_nrst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Core event inputs, sampled at an instruction boundary strobe; the entry failure inputs are taken in any cycle without a boundary exit.
  input wire logic i_boundary,
  input wire logic i_exception,
  input wire logic i_exception_bitmap_hit,
  input wire logic i_double_fault_invoke,
  input wire logic i_nmi,
  input wire logic i_external_interrupt,
  input wire logic i_init_signal,
  input wire logic i_startup_interprocessor_interrupt,
  input wire logic i_wait_for_startup_state,
  input wire logic i_system_management_interrupt,
  input wire logic i_after_io_retire,
  input wire logic i_interrupt_enable_flag,
  input wire logic i_set_interrupt_blocking,
  input wire logic i_stack_segment_load_blocking,
  input wire logic i_virtual_nmi_blocking,
  input wire logic i_task_switch,
  input wire logic i_processor_identify_instruction,
  input wire logic i_secure_env_leaf_instruction,
  input wire logic i_halt_instruction,
  input wire logic i_entry_fail,
  input wire logic [15:0] i_entry_fail_reason,
  // Write port into the guest control structure store, then the status interrupt.
  output logic o_store_valid,
  output logic [31:0] o_store_cause,
  output logic o_guest_exit,
  output logic o_irq
);

  // All block state in one packed struct.
  typedef struct packed {
    logic [31:0] cause;
    logic [exit_cause_pkg::CTL_WIDTH-1:0] ctl;
    logic [exit_cause_pkg::STS_WIDTH-1:0] sts;
    logic [exit_cause_pkg::STS_WIDTH-1:0] mask;
    logic store_valid;
    logic guest_exit;
    logic [31:0] rdata;
  } state_type;

  state_type state_q; // Registered state.
  state_type state_d; // Next state.
  logic exit_hit; // Some exit condition is true this boundary.
  logic [15:0] exit_reason; // Chosen basic reason.
  logic wr_en; // APB write in access phase.
  logic rd_en; // APB read in access phase.
  logic [exit_cause_pkg::STS_WIDTH-1:0] sts_set; // Events this cycle.

  // Read decode, used by the read path.
  function automatic logic [31:0] read_reg(input logic [7:0] addr, input state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      exit_cause_pkg::CAUSE_OFFSET: v = s.cause;
      exit_cause_pkg::CONTROL_OFFSET: v[exit_cause_pkg::CTL_WIDTH-1:0] = s.ctl;
      exit_cause_pkg::STATUS_OFFSET: v[exit_cause_pkg::STS_WIDTH-1:0] = s.sts;
      exit_cause_pkg::MASK_OFFSET: v[exit_cause_pkg::STS_WIDTH-1:0] = s.mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Address map check, so unmapped accesses answer with an error.
  function automatic logic addr_mapped(input logic [7:0] addr);
    return (addr == exit_cause_pkg::CAUSE_OFFSET) || (addr == exit_cause_pkg::CONTROL_OFFSET) ||
           (addr == exit_cause_pkg::STATUS_OFFSET) || (addr == exit_cause_pkg::MASK_OFFSET);
  endfunction

  // Priority encoder over all exit causes; first true branch wins.
  always_comb begin
    exit_hit = 1'b1;
    exit_reason = exit_cause_pkg::RSN_EXCEPTION_NMI;
    if (i_double_fault_invoke && i_exception && !i_exception_bitmap_hit) begin
      exit_reason = exit_cause_pkg::RSN_TRIPLE_FAULT;
    end else if (i_exception && i_exception_bitmap_hit) begin
      exit_reason = exit_cause_pkg::RSN_EXCEPTION_NMI;
    end else if (i_system_management_interrupt && i_after_io_retire) begin
      exit_reason = exit_cause_pkg::RSN_IO_SMI;
    end else if (i_system_management_interrupt) begin
      exit_reason = exit_cause_pkg::RSN_OTHER_SMI;
    end else if (i_init_signal) begin
      exit_reason = exit_cause_pkg::RSN_INIT;
    end else if (i_startup_interprocessor_interrupt && i_wait_for_startup_state) begin
      exit_reason = exit_cause_pkg::RSN_STARTUP;
    end else if (i_nmi && state_q.ctl[exit_cause_pkg::CTL_NMI_EXIT_BIT]) begin
      exit_reason = exit_cause_pkg::RSN_EXCEPTION_NMI;
    end else if (i_external_interrupt && state_q.ctl[exit_cause_pkg::CTL_EXT_EXIT_BIT]) begin
      exit_reason = exit_cause_pkg::RSN_EXT_INT;
    end else if (!i_virtual_nmi_blocking && !i_stack_segment_load_blocking &&
                 state_q.ctl[exit_cause_pkg::CTL_NMIWIN_EXIT_BIT]) begin
      exit_reason = exit_cause_pkg::RSN_NMI_WINDOW;
    end else if (i_interrupt_enable_flag && !i_set_interrupt_blocking &&
                 !i_stack_segment_load_blocking &&
                 state_q.ctl[exit_cause_pkg::CTL_INTWIN_EXIT_BIT]) begin
      exit_reason = exit_cause_pkg::RSN_INT_WINDOW;
    end else if (i_task_switch) begin
      exit_reason = exit_cause_pkg::RSN_TASK_SWITCH;
    end else if (i_processor_identify_instruction) begin
      exit_reason = exit_cause_pkg::RSN_IDENTIFY;
    end else if (i_secure_env_leaf_instruction) begin
      exit_reason = exit_cause_pkg::RSN_SECURE_LEAF;
    end else if (i_halt_instruction && state_q.ctl[exit_cause_pkg::CTL_HALT_EXIT_BIT]) begin
      exit_reason = exit_cause_pkg::RSN_HALT;
    end else begin
      exit_hit = 1'b0;
    end
  end

  // APB strobes; the slave answers in the first access cycle.
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;

  // Next-state logic: cause capture, registers and sticky status.
  always_comb begin
    state_d = state_q;
    state_d.store_valid = 1'b0;
    state_d.guest_exit = 1'b0;
    sts_set = '0;
    if (i_boundary && exit_hit) begin
      // Upper half is left zero; only one code is recorded.
      state_d.cause = {16'h0000, exit_reason};
      state_d.store_valid = 1'b1;
      state_d.guest_exit = 1'b1;
      sts_set[exit_cause_pkg::STS_EXIT_BIT] = 1'b1;
    end else if (i_entry_fail) begin
      // Entry failures use the same word layout as exits.
      state_d.cause = {16'h0000, i_entry_fail_reason};
      state_d.store_valid = 1'b1;
      sts_set[exit_cause_pkg::STS_ENTRY_FAIL_BIT] = 1'b1;
    end
    if (wr_en) begin
      if (i_paddr == exit_cause_pkg::CONTROL_OFFSET) begin
        state_d.ctl = i_pwdata[exit_cause_pkg::CTL_WIDTH-1:0];
      end
      if (i_paddr == exit_cause_pkg::STATUS_OFFSET) begin
        state_d.sts = state_q.sts & ~i_pwdata[exit_cause_pkg::STS_WIDTH-1:0];
      end
      if (i_paddr == exit_cause_pkg::MASK_OFFSET) begin
        state_d.mask = i_pwdata[exit_cause_pkg::STS_WIDTH-1:0];
      end
    end
    // A new event wins over a simultaneous clear.
    state_d.sts = state_d.sts | sts_set;
    if (rd_en) begin
      state_d.rdata = read_reg(i_paddr, state_q);
    end
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q.cause <= exit_cause_pkg::CAUSE_RESET;
      state_q.ctl <= exit_cause_pkg::CTL_RESET;
      state_q.sts <= '0;
      state_q.mask <= exit_cause_pkg::MASK_RESET;
      state_q.store_valid <= 1'b0;
      state_q.guest_exit <= 1'b0;
      state_q.rdata <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs: read data is combinational on the access cycle from registers.
  assign o_prdata = rd_en ? read_reg(i_paddr, state_q) : 32'h0000_0000;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_mapped(i_paddr);
  assign o_store_valid = state_q.store_valid;
  assign o_store_cause = state_q.cause;
  assign o_guest_exit = state_q.guest_exit;
  assign o_irq = |(state_q.sts & state_q.mask);

endmodule
